// [cow_pkg.sv]
// constants, types and register map of the clock output and watchdog registers
package cow_pkg;

    localparam logic [7:0] COW_OFS_PERIPH = 8'h04;
    localparam logic [7:0] COW_OFS_MEMORY = 8'h05;
    localparam logic [7:0] COW_OFS_WDOG = 8'h06;

    localparam logic [7:0] COW_RST_PERIPH = 8'hcf;
    localparam logic [7:0] COW_RST_MEMORY = 8'h7f;
    localparam logic [7:0] COW_RST_WDOG = 8'h80;

    // peripheral_clock_ctrl fields
    localparam int COW_P_USB_DRV = 7;
    localparam int COW_P_SIO_DRV = 6;
    localparam int COW_P_RATIO_HI = 5;
    localparam int COW_P_RATIO_LO = 4;
    localparam int COW_P_REFA_EN = 3;
    localparam int COW_P_REFB_EN = 2;
    localparam int COW_P_REFA_DRV = 1;
    localparam int COW_P_REFB_DRV = 0;
    // memory_clock_ctrl fields
    localparam int COW_M_THRESH = 7;
    localparam int COW_M_FB_EN = 6;
    localparam int COW_M_PAIRS = 6;
    // watchdog_ctrl fields
    localparam int COW_W_PIN_ROLE = 7;
    localparam int COW_W_REVERT = 6;
    localparam int COW_W_TEST = 5;
    localparam int COW_W_ALARM = 4;
    localparam int COW_W_TMO_HI = 3;

    // ratio codes as twice the cpu/graphics ratio, zero = frequency select default
    localparam logic [2:0] COW_RATIO_X2_DEF = 3'h0;
    localparam logic [2:0] COW_RATIO_X2_2 = 3'h4;
    localparam logic [2:0] COW_RATIO_X2_25 = 3'h5;
    localparam logic [2:0] COW_RATIO_X2_3 = 3'h6;

    // buffer input thresholds in millivolts
    localparam logic [10:0] COW_THR_DDR_0 = 11'h47e;
    localparam logic [10:0] COW_THR_DDR_1 = 11'h41a;
    localparam logic [10:0] COW_THR_SDR_0 = 11'h546;
    localparam logic [10:0] COW_THR_SDR_1 = 11'h4e2;

    localparam int COW_CLK_PERIOD_NS = 8;
    localparam int COW_SECOND_NS = 1000000000;
    localparam int COW_SECOND_CYCLES = COW_SECOND_NS / COW_CLK_PERIOD_NS;
    localparam int COW_RST_PULSE_NS = 1000;
    localparam int COW_RST_PULSE_CYCLES =
        (COW_RST_PULSE_NS + COW_CLK_PERIOD_NS - 1) / COW_CLK_PERIOD_NS;
    localparam int COW_TICK_W = 27;

    typedef enum logic [1:0] {
        COW_WD_OFF = 2'b00,
        COW_WD_RUN = 2'b01,
        COW_WD_FIRE = 2'b11,
        COW_WD_HOLD = 2'b10
    } cow_wd_e;

endpackage

// [cow_tick.sv]
// one-second tick generator for the watchdog
`timescale 1ns/100ps
`default_nettype none
module cow_tick
    import cow_pkg::*;
#(
    parameter int unsigned CYCLES = COW_SECOND_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic run_i,
    output logic tick_o
);
    typedef struct packed {
        logic [COW_TICK_W-1:0] count;
    } cow_tick_s;

    localparam logic [COW_TICK_W-1:0] LAST = COW_TICK_W'(CYCLES - 1);

    cow_tick_s s;
    cow_tick_s next_s;

    assign tick_o = run_i && !clear_i && (s.count == LAST);

    always_comb begin
        next_s = s;
        if (clear_i || tick_o) begin
            next_s.count = '0;
        end else if (run_i) begin
            next_s.count = s.count + COW_TICK_W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // cow_tick
`default_nettype wire

// [cow_regs.sv]
// clock output control, ratio select and watchdog registers
// Summary of operation
// RL1 - drive select bits: one gives normal drive, zero gives high drive
// RL2 - ratio field 00 default, 01 2/1, 10 2.5/1, 11 3/1
// RL3 - output enable one runs the clock, zero stops it low
// RL4 - second reference enable and drive act only in alternate processor mode
// RL5 - threshold bit: ddr 1.15V/1.05V, sdr 1.35V/1.25V
// RL6 - watchdog bit 7: one power-down input, zero reset output; resets to one
// RL7 - revert zero uses hardware straps after a watchdog reboot only
// RL8 - revert one reapplies the software setting before the last one
// RL9 - host always writes zero to the watchdog test bit
// RL10 - alarm flag set when the watchdog expires
// RL11 - alarm flag cleared when host clears the timeout field
// RL12 - four timeout bits select the period, all reset to zero
// RL13 - timeout zero is off, 1 to 15 gives that many seconds
// RL14 - software select input decides if software frequency settings count
// RL15 - count seconds while enabled; on expiry alarm and pulse reset pin
// RL16 - host writes to the alarm flag are ignored
`timescale 1ns/100ps
`default_nettype none
module cow_regs
    import cow_pkg::*;
#(
    parameter int unsigned SECOND_CYCLES = COW_SECOND_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic alternate_processor_mode_i,
    input wire logic ddr_mode_i,
    input wire logic sw_freq_sel_en_i,
    input wire logic [3:0] sw_freq_i,
    input wire logic [3:0] hw_freq_i,
    input wire logic power_down_in_n_i,
    output logic usb_clock_out_drive_normal_o,
    output logic superio_clock_out_drive_normal_o,
    output logic [2:0] ratio_x2_o,
    output logic reference_out_a_en_o,
    output logic reference_out_a_drive_normal_o,
    output logic reference_out_b_en_o,
    output logic reference_out_b_drive_normal_o,
    output logic feedback_clock_out_en_o,
    output logic [5:0] memory_clock_pair_en_o,
    output logic [10:0] buf_threshold_mv_o,
    output logic [3:0] freq_sel_o,
    output logic system_reset_out_n_o,
    output logic system_reset_out_oe_o,
    output logic power_down_o,
    output logic watchdog_alarm_flag_o
);
    typedef struct packed {
        logic [7:0] periph;
        logic [7:0] mem;
        logic pin_role;
        logic revert;
        logic watchdog_test_bit;
        logic alarm;
        logic [3:0] timeout;
        cow_wd_e wd;
        logic [3:0] secs;
        logic [7:0] rst_cnt;
        logic [3:0] cur_sw;
        logic [3:0] prev_sw;
        logic revert_active;
        logic [3:0] revert_freq;
        logic [3:0] freq;
        logic [7:0] rdata;
        logic refb_en;
        logic refb_drv;
        logic [2:0] ratio_x2;
        logic [10:0] thresh;
    } cow_state_s;

    localparam logic [7:0] PULSE = 8'(COW_RST_PULSE_CYCLES);

    cow_state_s s;
    cow_state_s next_s;
    logic tick;
    logic wr_wd;
    logic fire;

    assign wr_wd = reg_wr_i && (reg_addr_i == COW_OFS_WDOG);
    // any write to the watchdog byte restarts the second count
    assign fire = (s.wd == COW_WD_RUN) && !wr_wd && tick && (s.secs + 4'h1 == s.timeout);

    cow_tick #(
        .CYCLES(SECOND_CYCLES)
    ) u_tick (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .clear_i(wr_wd || (s.wd != COW_WD_RUN)),
        .run_i(s.wd == COW_WD_RUN),
        .tick_o(tick)
    );

    always_comb begin
        next_s = s;
        if (reg_wr_i && reg_addr_i == COW_OFS_PERIPH) begin
            next_s.periph = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == COW_OFS_MEMORY) begin
            next_s.mem = reg_wdata_i;
        end
        if (wr_wd) begin
            next_s.pin_role = reg_wdata_i[COW_W_PIN_ROLE];
            next_s.revert = reg_wdata_i[COW_W_REVERT];
            next_s.watchdog_test_bit = reg_wdata_i[COW_W_TEST]; // stored only [RL9]
            next_s.timeout = reg_wdata_i[COW_W_TMO_HI:0]; // [RL12]
            // the written alarm bit is dropped [RL16]
            if (reg_wdata_i[COW_W_TMO_HI:0] == 4'h0) begin
                next_s.alarm = 1'b0; // [RL11]
            end
        end
        // software setting history; only counts while software select is on [RL14]
        if (sw_freq_sel_en_i && sw_freq_i != s.cur_sw) begin
            next_s.prev_sw = s.cur_sw;
            next_s.cur_sw = sw_freq_i;
            next_s.revert_active = 1'b0;
        end
        case (s.wd)
            COW_WD_OFF: begin
                if (next_s.timeout != 4'h0 && !next_s.alarm) begin
                    next_s.wd = COW_WD_RUN; // [RL13]
                    next_s.secs = 4'h0;
                end
            end
            COW_WD_RUN: begin
                if (next_s.timeout == 4'h0) begin
                    next_s.wd = COW_WD_OFF; // [RL13]
                end else if (wr_wd) begin
                    next_s.secs = 4'h0;
                end else if (fire) begin
                    next_s.wd = COW_WD_FIRE; // [RL15]
                    next_s.alarm = 1'b1; // expiry needs a cycle with no watchdog write, so no clear competes [RL10]
                    next_s.rst_cnt = PULSE;
                    next_s.revert_active = 1'b1;
                    next_s.revert_freq = s.revert ? s.prev_sw : hw_freq_i; // [RL7] [RL8]
                end else if (tick) begin
                    next_s.secs = s.secs + 4'h1; // [RL15]
                end
            end
            COW_WD_FIRE: begin
                next_s.rst_cnt = s.rst_cnt - 8'h01;
                if (s.rst_cnt == 8'h01) begin
                    next_s.wd = COW_WD_HOLD;
                end
            end
            COW_WD_HOLD: begin
                if (!next_s.alarm) begin
                    next_s.wd = COW_WD_OFF;
                end
            end
            default: begin
                next_s.wd = COW_WD_OFF;
            end
        endcase
        // limitation: after a revert the override holds until software changes setting
        if (next_s.revert_active) begin
            next_s.freq = next_s.revert_freq; // [RL7] [RL8]
        end else begin
            next_s.freq = sw_freq_sel_en_i ? sw_freq_i : hw_freq_i; // [RL14]
        end
        // second reference is only steerable in the alternate processor mode [RL4]
        next_s.refb_en = alternate_processor_mode_i ? next_s.periph[COW_P_REFB_EN] : 1'b1;
        next_s.refb_drv = alternate_processor_mode_i ? next_s.periph[COW_P_REFB_DRV] : 1'b1;
        case (next_s.periph[COW_P_RATIO_HI:COW_P_RATIO_LO])
            2'b01: next_s.ratio_x2 = COW_RATIO_X2_2; // [RL2]
            2'b10: next_s.ratio_x2 = COW_RATIO_X2_25;
            2'b11: next_s.ratio_x2 = COW_RATIO_X2_3;
            default: next_s.ratio_x2 = COW_RATIO_X2_DEF;
        endcase
        if (ddr_mode_i) begin
            next_s.thresh = next_s.mem[COW_M_THRESH] ? COW_THR_DDR_1 : COW_THR_DDR_0; // [RL5]
        end else begin
            next_s.thresh = next_s.mem[COW_M_THRESH] ? COW_THR_SDR_1 : COW_THR_SDR_0; // [RL5]
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                COW_OFS_PERIPH: next_s.rdata = s.periph;
                COW_OFS_MEMORY: next_s.rdata = s.mem;
                COW_OFS_WDOG: next_s.rdata = {s.pin_role, s.revert, s.watchdog_test_bit,
                                              s.alarm, s.timeout};
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s <= '0;
            s.periph <= COW_RST_PERIPH;
            s.mem <= COW_RST_MEMORY;
            s.pin_role <= COW_RST_WDOG[COW_W_PIN_ROLE]; // [RL6]
            s.wd <= COW_WD_OFF;
            s.refb_en <= 1'b1;
            s.refb_drv <= 1'b1;
            s.thresh <= COW_THR_SDR_0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign usb_clock_out_drive_normal_o = s.periph[COW_P_USB_DRV]; // [RL1]
    assign superio_clock_out_drive_normal_o = s.periph[COW_P_SIO_DRV]; // [RL1]
    assign reference_out_a_drive_normal_o = s.periph[COW_P_REFA_DRV]; // [RL1]
    assign reference_out_b_drive_normal_o = s.refb_drv;
    assign reference_out_a_en_o = s.periph[COW_P_REFA_EN]; // [RL3]
    assign reference_out_b_en_o = s.refb_en;
    assign feedback_clock_out_en_o = s.mem[COW_M_FB_EN]; // [RL3]
    assign memory_clock_pair_en_o = s.mem[COW_M_PAIRS-1:0]; // [RL3]
    assign ratio_x2_o = s.ratio_x2;
    assign buf_threshold_mv_o = s.thresh;
    assign freq_sel_o = s.freq;
    assign watchdog_alarm_flag_o = s.alarm;
    // shared pin: driven only in the reset-output role [RL6]
    assign system_reset_out_oe_o = !s.pin_role;
    assign system_reset_out_n_o = !(s.wd == COW_WD_FIRE && !s.pin_role); // [RL15]
    assign power_down_o = s.pin_role && !power_down_in_n_i;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence fire_seq;
        fire && !reset_i;
    endsequence
    sequence pulse_seq;
        (s.wd == COW_WD_FIRE)[*8];
    endsequence

    AST_ALARM_SET: assert property (fire_seq |=> watchdog_alarm_flag_o) // [RL10]
        else $error("alarm not set on expiry");
    AST_ALARM_CLR: assert property (wr_wd && reg_wdata_i[3:0] == 4'h0 // [RL11]
        |=> !watchdog_alarm_flag_o)
        else $error("alarm not cleared");
    AST_ALARM_IGN: assert property (wr_wd && reg_wdata_i[3:0] != 4'h0
        |=> watchdog_alarm_flag_o == $past(watchdog_alarm_flag_o)) // [RL16]
        else $error("alarm changed by write");
    AST_PULSE: assert property (fire_seq |=> pulse_seq) // [RL15]
        else $error("reset pulse too short");
    AST_PIN_ROLE: assert property (s.pin_role // [RL6]
        |-> system_reset_out_n_o && !system_reset_out_oe_o)
        else $error("pin driven in power-down role");
    AST_RATIO: assert property (s.periph[5:4] == 2'b10 // [RL2]
        |-> ratio_x2_o == COW_RATIO_X2_25)
        else $error("ratio mismatch");
    // a write may move the select bit, so only quiet cycles are judged
    AST_THRESH: assert property (ddr_mode_i && !reg_wr_i // [RL5]
        |=> buf_threshold_mv_o == (s.mem[COW_M_THRESH] ? COW_THR_DDR_1 : COW_THR_DDR_0))
        else $error("ddr threshold wrong");
    AST_REFB: assert property (!alternate_processor_mode_i |=> reference_out_b_en_o
        && reference_out_b_drive_normal_o) // [RL4]
        else $error("second reference steered outside alternate mode");
    AST_REVERT: assert property ((fire_seq and s.revert) // [RL8]
        |=> freq_sel_o == $past(s.prev_sw))
        else $error("revert frequency wrong");
    // a pulse already under way may finish after the timeout is cleared
    AST_OFF: assert property (s.timeout == 4'h0 && s.wd != COW_WD_FIRE // [RL13]
        |=> s.wd != COW_WD_FIRE)
        else $error("watchdog fired while off");
endmodule // cow_regs
`default_nettype wire

// [cow_sys_model.sv]
// system reset logic at the shared power-down / reset pin
`timescale 1ns/100ps
`default_nettype none
module cow_sys_model (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic pin_oe_i,
    input wire logic pin_out_n_i,
    input wire logic pd_req_i,
    output logic pin_level_o,
    output logic [15:0] pulse_len_o,
    output logic [7:0] pulse_cnt_o
);
    logic [15:0] run;
    // a released pin rests at its pull-up level unless power-down is requested
    assign pin_level_o = pin_oe_i ? pin_out_n_i : !pd_req_i;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            run <= 16'h0;
            pulse_len_o <= 16'h0;
            pulse_cnt_o <= 8'h0;
        end else if (pin_oe_i && !pin_level_o) begin
            run <= run + 16'h1;
        end else if (run != 16'h0) begin
            pulse_len_o <= run;
            pulse_cnt_o <= pulse_cnt_o + 8'h1;
            run <= 16'h0;
        end
    end
endmodule // cow_sys_model
`default_nettype wire

// [cow_regs_test.sv]
// self-checking testbench of the clock output and watchdog registers
`timescale 1ns/100ps
`default_nettype none
module cow_regs_test;
    import cow_pkg::*;
    localparam int SEC = 20;
    logic mclk_i, reset_i, reg_wr_i, reg_rd_i, alternate_processor_mode_i, ddr_mode_i;
    logic sw_freq_sel_en_i, power_down_in_n_i, pd_req;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pcnt, p0, d;
    logic [3:0] sw_freq_i, hw_freq_i, freq_sel_o;
    logic [2:0] ratio_x2_o;
    logic [5:0] memory_clock_pair_en_o;
    logic [10:0] buf_threshold_mv_o;
    logic [15:0] plen;
    logic usb_o, sio_o, refa_en, refa_drv, refb_en, refb_drv, fb_en, rst_n, rst_oe, pd_o, alarm;
    logic [2:0] rx[4] = '{COW_RATIO_X2_DEF, COW_RATIO_X2_2, COW_RATIO_X2_25, COW_RATIO_X2_3};
    logic [10:0] th[4] = '{COW_THR_SDR_0, COW_THR_SDR_1, COW_THR_DDR_0, COW_THR_DDR_1};
    int fail_count, cmp_count, n;

    cow_regs #(.SECOND_CYCLES(SEC)) dut_u (
        .mclk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .alternate_processor_mode_i, .ddr_mode_i, .sw_freq_sel_en_i, .sw_freq_i, .hw_freq_i,
        .power_down_in_n_i, .usb_clock_out_drive_normal_o(usb_o),
        .superio_clock_out_drive_normal_o(sio_o), .ratio_x2_o,
        .reference_out_a_en_o(refa_en), .reference_out_a_drive_normal_o(refa_drv),
        .reference_out_b_en_o(refb_en), .reference_out_b_drive_normal_o(refb_drv),
        .feedback_clock_out_en_o(fb_en), .memory_clock_pair_en_o, .buf_threshold_mv_o,
        .freq_sel_o, .system_reset_out_n_o(rst_n), .system_reset_out_oe_o(rst_oe),
        .power_down_o(pd_o), .watchdog_alarm_flag_o(alarm));
    cow_sys_model sys_u (.mclk_i, .reset_i, .pin_oe_i(rst_oe), .pin_out_n_i(rst_n),
        .pd_req_i(pd_req), .pin_level_o(power_down_in_n_i), .pulse_len_o(plen),
        .pulse_cnt_o(pcnt));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // byte write; returns once the written value has reached the outputs
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        @(posedge mclk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("read_data", {8'h0, e}, {8'h0, reg_rdata_o});
    endtask

    // bounded wait; the count lets the caller judge the timeout period
    task automatic wait_alarm(output int k);
        k = 0;
        while (alarm !== 1'b1 && k < 400) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        if (k >= 400) begin
            fail_count++;
            $display("unexpected alarm_wait expected 1 seen 0");
            end_sim();
        end
    endtask

    initial begin
        reset_i = 1'b1;
        {reg_wr_i, reg_rd_i, alternate_processor_mode_i, ddr_mode_i} = 4'h0;
        {reg_addr_i, reg_wdata_i, sw_freq_i, sw_freq_sel_en_i, pd_req} = 22'h0;
        hw_freq_i = 4'ha;
        fail_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(COW_OFS_PERIPH, 8'hcf);
        rd(COW_OFS_MEMORY, 8'h7f);
        rd(COW_OFS_WDOG, 8'h80);
        rd(8'h07, 8'h00);
        chk("thresh", COW_THR_SDR_0, buf_threshold_mv_o);
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1], i[1:0], i[1], i[0], i[0], ~i[0]};
            @(posedge mclk_i);
            alternate_processor_mode_i <= i[1];
            wr(COW_OFS_PERIPH, d);
            rd(COW_OFS_PERIPH, d);
            chk("usb_drive", d[7], usb_o);
            chk("sio_drive", d[6], sio_o);
            chk("ratio", rx[i], ratio_x2_o);
            chk("refa_en", d[3], refa_en);
            chk("refa_drive", d[1], refa_drv);
            chk("refb_en", i[1] ? d[2] : 1'b1, refb_en);
            chk("refb_drive", i[1] ? d[0] : 1'b1, refb_drv);
        end
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1], 6'h15 << i[0]};
            @(posedge mclk_i);
            ddr_mode_i <= i[1];
            wr(COW_OFS_MEMORY, d);
            rd(COW_OFS_MEMORY, d);
            chk("thresh", th[i], buf_threshold_mv_o);
            chk("fb_en", d[6], fb_en);
            chk("pairs", d[5:0], memory_clock_pair_en_o);
        end
        // host writes below keep the test bit at zero
        wr(COW_OFS_WDOG, 8'h80);
        @(posedge mclk_i);
        pd_req <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk("power_down", 1, pd_o);
        chk("pin_oe", 0, rst_oe);
        wr(COW_OFS_WDOG, 8'h10);
        pd_req <= 1'b0;
        chk("pin_oe", 1, rst_oe);
        chk("power_down", 0, pd_o);
        rd(COW_OFS_WDOG, 8'h00);
        for (int t = 1; t < 4; t += 2) begin
            p0 = pcnt;
            wr(COW_OFS_WDOG, {4'h0, t[3:0]});
            wait_alarm(n);
            chk("period_ok", 1, n >= SEC * t - 6 && n <= SEC * t + 6);
            chk("reset_pin", 0, rst_n);
            repeat (140) @(posedge mclk_i);
            #1;
            chk("pulse_len", 16'(COW_RST_PULSE_CYCLES), plen);
            chk("pulse_cnt", p0 + 8'h1, pcnt);
            wr(COW_OFS_WDOG, 8'h05);
            chk("alarm_held", 1, alarm);
            wr(COW_OFS_WDOG, 8'h00);
            chk("alarm_clear", 0, alarm);
        end
        p0 = pcnt;
        wr(COW_OFS_WDOG, 8'h81);
        wait_alarm(n);
        repeat (140) @(posedge mclk_i);
        #1;
        chk("pulse_cnt", p0, pcnt);
        wr(COW_OFS_WDOG, 8'h00);
        @(posedge mclk_i);
        sw_freq_sel_en_i <= 1'b1;
        sw_freq_i <= 4'h3;
        repeat (4) @(posedge mclk_i);
        sw_freq_i <= 4'h9;
        repeat (4) @(posedge mclk_i);
        #1;
        chk("freq_sw", 4'h9, freq_sel_o);
        wr(COW_OFS_WDOG, 8'h41);
        wait_alarm(n);
        @(posedge mclk_i);
        #1;
        chk("freq_revert", 4'h3, freq_sel_o);
        wr(COW_OFS_WDOG, 8'h00);
        wr(COW_OFS_WDOG, 8'h01);
        wait_alarm(n);
        @(posedge mclk_i);
        #1;
        chk("freq_hw", hw_freq_i, freq_sel_o);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(COW_OFS_WDOG, 8'h80);
        chk("alarm_reset", 0, alarm);
        end_sim();
    end
endmodule // cow_regs_test
`default_nettype wire
